/* hdl/rrx_exec.sv */
// executor for return, interrupt return, literal return and rotate left through carry
// What this block does
// [RL1] interrupt return pops stack, loads counter
// [RL2] interrupt return sets global interrupt enable
// [RL3] interrupt return: one word, two cycles
// [RL4] subroutine return pops stack, flags unchanged
// [RL5] subroutine return loads counter from top
// [RL6] subroutine return: two cycles, one word
// [RL7] literal return writes literal to accumulator
// [RL8] literal return pops stack, loads counter
// [RL9] literal return: two cycles, one word
// [RL10] rotate file register left through carry
// [RL11] destination select picks accumulator or file
// [RL12] returns flush prefetch, insert no-op cycle
`timescale 1ns/1ps
`default_nettype none
module rrx_exec
  import rrx_pkg::*;
(
  // clocking
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // instruction issue
  input  wire logic               instr_valid,
  input  wire logic [OP_W-1:0]    instr_op,
  input  wire logic [DATA_W-1:0]  instr_literal,
  input  wire logic [FADDR_W-1:0] instr_faddr,
  input  wire logic               instr_dest,
  input  wire logic [DATA_W-1:0]  file_rdata,
  // call side of the stack
  input  wire logic               call_push,
  input  wire logic [PC_W-1:0]    call_addr,
  // status
  output logic                    busy,
  output logic                    done,
  output logic                    prefetch_flush,
  output logic                    fetch_load,
  output logic [PC_W-1:0]         pc_out,
  output logic [DATA_W-1:0]       acc_out,
  output logic                    carry_out,
  output logic [DATA_W-1:0]       interrupt_control_reg,
  output logic                    stack_empty,
  // file register write
  output logic                    file_we,
  output logic [FADDR_W-1:0]      file_waddr,
  output logic [DATA_W-1:0]       file_wdata
);
  rrx_stack_if stk ();

  rrx_return_stack u_stack
  (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .stk (stk)
  );

  rrx_state_e          state_reg;
  rrx_op_e             op_reg;
  logic [1:0]          q_reg;
  logic [1:0]          icyc_reg;
  logic [DATA_W-1:0]   lit_reg;
  logic [DATA_W:0]     rot;
  logic                q_end;
  logic                start;
  logic                pop_now;

  assign q_end   = (q_reg == Q_LAST);
  assign start   = ce && (state_reg == RRX_ST_IDLE) && instr_valid && !call_push;
  assign rot     = rrx_rotate_left(file_rdata, carry_out);
  assign pop_now = ce && (state_reg == RRX_ST_EXEC) && q_end
                   && (op_reg != RRX_OP_ROTATE_LEFT);

  assign stk.push      = call_push && (state_reg == RRX_ST_IDLE);
  assign stk.push_addr = call_addr;
  // [RL1] pop on return
  assign stk.pop       = pop_now;

  // quarter-cycle counter within one instruction cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q_reg <= Q_ZERO;
    else if (ce)
    begin
      if (state_reg == RRX_ST_IDLE && !start)
        q_reg <= Q_ZERO;
      else
        q_reg <= q_reg + 1'b1;
    end
  end

  // sequencing: one exec cycle, then a no-op flush cycle for returns
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= RRX_ST_IDLE;
      op_reg    <= RRX_OP_SUBROUTINE_RETURN;
      lit_reg   <= '0;
      icyc_reg  <= '0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        RRX_ST_IDLE:
          if (start)
          begin
            state_reg <= RRX_ST_EXEC;
            op_reg    <= rrx_op_e'(instr_op);
            lit_reg   <= instr_literal;
            icyc_reg  <= 2'(1);
          end
        RRX_ST_EXEC:
          if (q_end)
          begin
            // [RL3] [RL6] [RL9] second cycle for returns
            if (op_reg != RRX_OP_ROTATE_LEFT && icyc_reg < 2'(RET_ICYCLES))
              state_reg <= RRX_ST_FLUSH;
            else
              state_reg <= RRX_ST_IDLE;
            icyc_reg <= icyc_reg + 1'b1;
          end
        RRX_ST_FLUSH:
          if (q_end)
            state_reg <= RRX_ST_IDLE;
        // the spare code can only come from an upset; fall back to idle
        default:
          state_reg <= RRX_ST_IDLE;
      endcase
    end
  end

  // handshake outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy           <= 1'b0;
      done           <= 1'b0;
      prefetch_flush <= 1'b0;
      fetch_load     <= 1'b0;
    end
    else if (ce)
    begin
      busy           <= start || (state_reg != RRX_ST_IDLE && !(q_end &&
                        (state_reg == RRX_ST_FLUSH || op_reg == RRX_OP_ROTATE_LEFT)));
      done           <= q_end && (state_reg == RRX_ST_FLUSH
                        || (state_reg == RRX_ST_EXEC && op_reg == RRX_OP_ROTATE_LEFT));
      // [RL12] discard prefetch, no-op cycle
      prefetch_flush <= pop_now;
      fetch_load     <= q_end && state_reg == RRX_ST_FLUSH;
    end
  end

  // program counter comes from the popped stack top entry
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pc_out <= '0;
    else if (ce && pop_now)
      // [RL5] [RL8] load from top
      pc_out <= stk.top_entry;
  end

  // accumulator, carry and interrupt control; returns touch no flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_out               <= '0;
      carry_out             <= 1'b0;
      interrupt_control_reg <= '0;
    end
    else if (ce && state_reg == RRX_ST_EXEC && q_end)
    begin
      unique case (op_reg)
        RRX_OP_INTERRUPT_RETURN:
          // [RL2] set global interrupt enable
          interrupt_control_reg[GLOBAL_INT_EN_BIT] <= 1'b1;
        RRX_OP_SUBROUTINE_RETURN:
          // [RL4] flags left alone
          carry_out <= carry_out;
        RRX_OP_RETURN_WITH_LITERAL:
          // [RL7] literal into accumulator
          acc_out <= lit_reg;
        RRX_OP_ROTATE_LEFT:
        begin
          // [RL10] old top bit to carry
          carry_out <= rot[DATA_W];
          // [RL11] accumulator destination
          if (instr_dest == DEST_ACC)
            acc_out <= rot[DATA_W-1:0];
        end
      endcase
    end
  end

  // file write-back for rotate with file destination
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      file_we     <= 1'b0;
      file_waddr  <= '0;
      file_wdata  <= '0;
      stack_empty <= 1'b1;
    end
    else if (ce)
    begin
      stack_empty <= stk.empty;
      // [RL11] file destination
      file_we     <= state_reg == RRX_ST_EXEC && q_end
                     && op_reg == RRX_OP_ROTATE_LEFT && instr_dest == DEST_FILE;
      file_waddr  <= instr_faddr;
      file_wdata  <= rot[DATA_W-1:0];
    end
  end
endmodule
`default_nettype wire

/* hdl/rrx_pkg.sv */
// package with encodings, widths and timing counts for the return and rotate executor
package rrx_pkg;
  localparam int unsigned PC_W         = 12;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FADDR_W      = 7;
  localparam int unsigned STACK_DEPTH  = 8;
  localparam int unsigned SP_W         = 3;
  localparam int unsigned GLOBAL_INT_EN_BIT = 7;
  localparam int unsigned OP_W         = 2;
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned ICYCLE_NS    = 400;
  // one instruction cycle is four clocks
  localparam int unsigned ICYCLE_CLKS  = (ICYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RET_ICYCLES  = 2;
  localparam int unsigned ROT_ICYCLES  = 1;
  localparam logic [1:0]  Q_LAST       = 2'(ICYCLE_CLKS - 1);
  localparam logic [1:0]  Q_ZERO       = 2'h0;
  localparam logic        DEST_ACC     = 1'b0;
  localparam logic        DEST_FILE    = 1'b1;

  typedef enum logic [OP_W-1:0]
  {
    RRX_OP_INTERRUPT_RETURN    = 2'b00,
    RRX_OP_SUBROUTINE_RETURN   = 2'b01,
    RRX_OP_RETURN_WITH_LITERAL = 2'b10,
    RRX_OP_ROTATE_LEFT         = 2'b11
  } rrx_op_e;

  typedef enum logic [1:0]
  {
    RRX_ST_IDLE  = 2'b00,
    RRX_ST_EXEC  = 2'b01,
    RRX_ST_FLUSH = 2'b10
  } rrx_state_e;

  function automatic logic [DATA_W:0] rrx_rotate_left(input logic [DATA_W-1:0] val,
                                                      input logic              cin);
    rrx_rotate_left = {val, cin};
  endfunction
endpackage

/* hdl/rrx_return_stack.sv */
// hardware return stack, circular, with registered top entry
`timescale 1ns/1ps
`default_nettype none
module rrx_return_stack
  import rrx_pkg::*;
(
  // clocking
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // stack port
  rrx_stack_if.mem  stk
);
  logic [PC_W-1:0] mem_reg [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [SP_W:0]   count_reg;
  logic [PC_W-1:0] top_reg;

  assign stk.top_entry = top_reg;
  assign stk.empty     = (count_reg == '0);

  always_ff @(posedge clk)
  begin
    if (ce && stk.push)
      mem_reg[sp_reg] <= stk.push_addr;
  end

  // overflow wraps silently like the real core; underflow reads stale data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sp_reg    <= '0;
      count_reg <= '0;
      top_reg   <= '0;
    end
    else if (ce)
    begin
      if (stk.push)
      begin
        sp_reg  <= sp_reg + 1'b1;
        top_reg <= stk.push_addr;
        if (count_reg != (SP_W+1)'(STACK_DEPTH))
          count_reg <= count_reg + 1'b1;
      end
      else if (stk.pop)
      begin
        sp_reg  <= sp_reg - 1'b1;
        top_reg <= mem_reg[sp_reg - 3'(2)];
        if (count_reg != '0)
          count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/rrx_stack_if.sv */
// interface between the executor and its return stack memory
`timescale 1ns/1ps
`default_nettype none
interface rrx_stack_if;
  import rrx_pkg::*;
  logic            push;
  logic [PC_W-1:0] push_addr;
  logic            pop;
  logic [PC_W-1:0] top_entry;
  logic            empty;
  modport core (output push, output push_addr, output pop, input top_entry, input empty);
  modport mem  (input push, input push_addr, input pop, output top_entry, output empty);
endinterface
`default_nettype wire

/* test/rrx_exec_assertions.sv */
// checker on the executor ports
`timescale 1ns/1ps
`default_nettype none
module rrx_exec_assertions
  import rrx_pkg::*;
(
  // clocking
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ce,
  // issue
  input wire logic              instr_valid,
  input wire logic [OP_W-1:0]   instr_op,
  input wire logic [DATA_W-1:0] instr_literal,
  input wire logic              instr_dest,
  input wire logic              call_push,
  // results
  input wire logic              busy,
  input wire logic              done,
  input wire logic              prefetch_flush,
  input wire logic              fetch_load,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic [DATA_W-1:0] interrupt_control_reg,
  input wire logic              file_we
);
  logic take;
  logic rot;
  assign take = instr_valid && !busy && !call_push;
  assign rot = instr_op == RRX_OP_ROTATE_LEFT;
  // ce low freezes the sequencer, so the fixed counts only hold while it stays high
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);
  rot_done_a: assert property (take && rot |-> ##4 (done && !busy))
    else $error("rotate did not finish in four clocks");
  rot_dest_a: assert property (take && rot |-> ##4 file_we == $past(instr_dest, 4))
    else $error("rotate destination wrong");
  ret_flush_a: assert property (take && !rot |-> ##4 prefetch_flush ##4 (done && fetch_load))
    else $error("return flush or refetch out of place");
  ret_busy_a: assert property (take && !rot |=> busy [*7] ##1 !busy)
    else $error("return busy length wrong");
  int_enable_set_a: assert property (take && instr_op == RRX_OP_INTERRUPT_RETURN |->
    ##4 interrupt_control_reg == ($past(interrupt_control_reg, 4) | 8'h80))
    else $error("interrupt enable not set alone");
  lit_acc_a: assert property (take && instr_op == RRX_OP_RETURN_WITH_LITERAL |->
    ##4 acc_out == $past(instr_literal, 4))
    else $error("literal not in accumulator");
  acc_keep_a: assert property (take && instr_op[1] == 1'b0 |-> ##4 acc_out == $past(acc_out, 4))
    else $error("plain return changed accumulator");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one clock");
endmodule
bind rrx_exec rrx_exec_assertions i_chk (.clk, .rst, .ce, .instr_valid, .instr_op,
  .instr_literal, .instr_dest, .call_push, .busy, .done, .prefetch_flush, .fetch_load,
  .acc_out, .interrupt_control_reg, .file_we);
`default_nettype wire

/* test/rrx_exec_bench.sv */
// self-checking bench for the return and rotate executor
`timescale 1ns/1ps
`default_nettype none
module rrx_exec_bench
  import rrx_pkg::*;
;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                ce = 1'b1;
  logic                instr_valid = 1'b0;
  logic                instr_dest = 1'b0;
  logic                call_push = 1'b0;
  logic [OP_W-1:0]     instr_op = 2'h0;
  logic [DATA_W-1:0]   instr_literal = 8'h00;
  logic [FADDR_W-1:0]  instr_faddr = 7'h7f;
  logic [DATA_W-1:0]   file_rdata = 8'h00;
  logic [PC_W-1:0]     call_addr = 12'h000;
  logic                busy, done, prefetch_flush, fetch_load, carry_out, stack_empty, file_we;
  logic [PC_W-1:0]     pc_out;
  logic [DATA_W-1:0]   acc_out, interrupt_control_reg, file_wdata;
  logic [FADDR_W-1:0]  file_waddr;
  int                  miscompares = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;

  rrx_exec i_dut (.clk, .rst, .ce, .instr_valid, .instr_op, .instr_literal, .instr_faddr,
    .instr_dest, .file_rdata, .call_push, .call_addr, .busy, .done, .prefetch_flush,
    .fetch_load, .pc_out, .acc_out, .carry_out, .interrupt_control_reg, .stack_empty,
    .file_we, .file_waddr, .file_wdata);

  always #50 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // the run needs about 70 clocks
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 1000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic push(input logic [PC_W-1:0] a);
    call_addr = a;
    call_push = 1'b1;
    @(posedge clk);
    #1 call_push = 1'b0;
    // one idle clock so back-to-back pushes never lower and raise the strobe in one step
    @(posedge clk);
    #1;
  endtask

  // issue one instruction and stop in the clock where done shows
  task automatic run(input rrx_op_e op, input logic [7:0] k, input logic d, input logic [7:0] rd);
    int c;
    // the taking edge is the first clock of the instruction
    c = 1;
    instr_op = op;
    instr_literal = k;
    instr_dest = d;
    file_rdata = rd;
    instr_valid = 1'b1;
    @(posedge clk);
    #1 instr_valid = 1'b0;
    while (done !== 1'b1 && c < 20)
    begin
      @(posedge clk);
      #1 c++;
    end
    chk("clocks", 12'(((op == RRX_OP_ROTATE_LEFT) ? ROT_ICYCLES : RET_ICYCLES) * ICYCLE_CLKS), 12'(c));
    chk("fetch_load", op != RRX_OP_ROTATE_LEFT, fetch_load);
    chk("file_we", op == RRX_OP_ROTATE_LEFT && d, file_we);
  endtask

  task automatic t_returns();
    chk("stack_empty", 1, stack_empty);
    push(12'h123);
    push(12'hfff);
    chk("stack_empty", 0, stack_empty);
    run(RRX_OP_SUBROUTINE_RETURN, 8'h55, 1'b0, 8'h00);
    chk("pc", 12'hfff, pc_out);
    chk("acc", 8'h00, acc_out);
    run(RRX_OP_INTERRUPT_RETURN, 8'h55, 1'b0, 8'h00);
    chk("pc", 12'h123, pc_out);
    chk("interrupt_control_reg", 8'h80, interrupt_control_reg);
  endtask

  task automatic t_literal();
    push(12'h0a5);
    run(RRX_OP_RETURN_WITH_LITERAL, 8'hff, 1'b0, 8'h00);
    chk("acc", 8'hff, acc_out);
    chk("pc", 12'h0a5, pc_out);
    push(12'h7e0);
    run(RRX_OP_RETURN_WITH_LITERAL, 8'h00, 1'b0, 8'h00);
    chk("acc", 8'h00, acc_out);
    chk("pc", 12'h7e0, pc_out);
  endtask

  task automatic t_rotate();
    run(RRX_OP_ROTATE_LEFT, 8'h00, 1'b0, 8'he6);
    chk("acc", 8'hcc, acc_out);
    chk("carry", 1, carry_out);
    run(RRX_OP_ROTATE_LEFT, 8'h00, 1'b1, 8'h80);
    chk("wdata", 8'h01, file_wdata);
    chk("waddr", 7'h7f, file_waddr);
    chk("carry", 1, carry_out);
    chk("acc", 8'hcc, acc_out);
  endtask

  // ce low mid-instruction stretches it by the frozen clocks and holds every output
  task automatic t_freeze();
    push(12'h3c3);
    instr_op = RRX_OP_SUBROUTINE_RETURN;
    instr_valid = 1'b1;
    @(posedge clk);
    #1 instr_valid = 1'b0;
    ce = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk("busy", 1, busy);
    chk("pc", 12'h7e0, pc_out);
    ce = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("pc", 12'h3c3, pc_out);
    chk("done", 0, done);
    @(posedge clk);
    #1 chk("done", 1, done);
    chk("carry", 1, carry_out);
    chk("acc", 8'hcc, acc_out);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_returns();
    t_literal();
    t_rotate();
    t_freeze();
    give_verdict();
  end
endmodule
`default_nettype wire
